/* common/ctk_pkg.sv */
`default_nettype none
package ctk_pkg;
   // ----------------------------------------------------------------
   // Structure
   // ----------------------------------------------------------------
   localparam int CTK_NMOD = 5;
   localparam int CTK_NKEY = 4;
   localparam int CTK_AW   = 12;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [11:0] ADR_GCTRL    = 12'h000;
   localparam logic [11:0] ADR_PRELOAD  = 12'h004;
   localparam logic [11:0] ADR_CALIB    = 12'h008;
   localparam logic [11:0] ADR_IRQ      = 12'h00C;
   localparam logic [11:0] ADR_MOD_BASE = 12'h040;
   localparam logic [11:0] MOD_STRIDE   = 12'h010;
   localparam logic [11:0] MOD_CTRL0    = 12'h000;
   localparam logic [11:0] MOD_CTRL1    = 12'h004;
   localparam logic [11:0] MOD_COUNT    = 12'h008;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int G_SLOT_OV  = 6;
   localparam int G_START    = 5;
   localparam int G_SENSE_OV = 4;
   localparam int G_CALIB_OV = 3;
   localparam int G_SHARED   = 2;
   localparam int G_CALSEL   = 0;
   localparam int IRQ_REQ    = 0;
   localparam int C0_MUX     = 6;
   localparam int C0_DBL     = 5;
   localparam int C0_FILT    = 4;
   localparam int C0_HOPHW   = 3;
   localparam int C0_HOPF    = 0;
   localparam int C1_TSS     = 7;
   localparam int C1_ROEN    = 5;
   localparam int C1_KOEN    = 4;
   localparam int C1_PAD     = 0;
   localparam logic [7:0] C1_WMASK = 8'hBF;

   // ----------------------------------------------------------------
   // Reset values and counter limits
   // ----------------------------------------------------------------
   localparam logic [7:0]  CTRL_RST  = 8'h00;
   localparam logic [4:0]  UNIT_MAX  = 5'h1F;
   localparam logic [7:0]  SLOT_MAX  = 8'hFF;
   localparam logic [15:0] CNT_MAX   = 16'hFFFF;
   localparam logic [2:0]  DIV_LAST  = 3'h7;
   localparam logic [1:0]  DIV4_LAST = 2'h3;

   // Hop frequencies in kHz, index is the software code
   localparam logic [7:0][10:0] HOP_KHZ = {
      11'd1125, 11'd1111, 11'd1099, 11'd1085,
      11'd1074, 11'd1059, 11'd1040, 11'd1020};

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [CTK_AW-1:0] paddr;
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [31:0]       pwdata;
   } ctk_apb_req_t;

   typedef struct packed {
      logic [7:0]                  preload;
      logic                        start;
      logic                        start_q;
      logic                        shared;
      logic                        slot_ov;
      logic                        sense_ov;
      logic                        calib_ov;
      logic                        irq;
      logic                        run;
      logic                        sync;
      logic [1:0]                  cal_sel;
      logic [2:0]                  div;
      logic [15:0]                 calib;
      logic [CTK_NMOD-1:0][7:0]    ctrl0;
      logic [CTK_NMOD-1:0][7:0]    ctrl1;
      logic [CTK_NMOD-1:0][7:0]    slot;
      logic [CTK_NMOD-1:0][4:0]    unit;
      logic [CTK_NMOD-1:0][15:0]   sense;
      logic [CTK_NMOD-1:0]         done;
      logic [31:0]                 rdata;
   } ctk_state_t;
endpackage
`default_nettype wire

/* design/ctk_scan.sv */
`default_nettype none
module ctk_scan
   import ctk_pkg::*;
(
   input  wire logic                         i_clk,
   input  wire logic                         i_resetn,
   input  wire logic                         i_ce,
   input  wire ctk_apb_req_t                 i_apb,
   output logic                              o_pready,
   output logic                              o_pslverr,
   output logic [31:0]                       o_prdata,
   input  wire logic [CTK_NMOD*CTK_NKEY-1:0] i_key_osc,
   input  wire logic [CTK_NMOD-1:0]          i_ref_osc,
   output logic [CTK_NMOD*CTK_NKEY-1:0]      o_key_osc_run,
   output logic [CTK_NMOD-1:0]               o_ref_osc_run,
   output logic [CTK_NMOD*CTK_NKEY-1:0]      o_pad_sense_en,
   output logic [CTK_NMOD-1:0]               o_freq_double,
   output logic [CTK_NMOD-1:0]               o_filter_en,
   output logic [CTK_NMOD-1:0]               o_hop_hw,
   output logic [CTK_NMOD*3-1:0]             o_hop_freq_sel,
   output logic [CTK_NMOD*11-1:0]            o_hop_khz,
   output logic                              o_osc_sync,
   output logic                              o_touch_irq
);

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   function automatic logic mod_hit(input logic [11:0] a, input int m,
                                    input logic [11:0] off);
      logic [11:0] base;
      base = 12'(ADR_MOD_BASE + 12'(m) * MOD_STRIDE);
      return a == 12'(base + off);
   endfunction

   function automatic logic reg_hit(input logic [11:0] a);
      logic h;
      h = 1'b0;
      if (a == ADR_GCTRL) begin
         h = 1'b1;
      end else if (a == ADR_PRELOAD) begin
         h = 1'b1;
      end else if (a == ADR_CALIB) begin
         h = 1'b1;
      end else if (a == ADR_IRQ) begin
         h = 1'b1;
      end
      for (int m = 0; m < CTK_NMOD; m++) begin
         if (mod_hit(a, m, MOD_CTRL0) || mod_hit(a, m, MOD_CTRL1) ||
             mod_hit(a, m, MOD_COUNT)) begin
            h = 1'b1;
         end
      end
      return h;
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   ctk_state_t state_ff;
   ctk_state_t nxt_state;

   logic                setup;
   logic                access;
   logic                wr;
   logic                hit;
   logic                rise;
   logic                tick4;
   logic                cal_tick;
   logic                gov_done;
   logic                slot_end;
   logic [CTK_NMOD-1:0] active;
   logic [CTK_NMOD-1:0] part;
   logic [CTK_NMOD-1:0] mod_on;
   logic [CTK_NMOD-1:0] slot_tick;
   logic [CTK_NMOD-1:0] key_pulse;
   logic                sense_wrap;
   logic                calib_wrap;
   logic                clr_slot;
   logic                set_slot_sw;
   logic                clr_sense;
   logic                clr_calib;
   logic                clr_irq;
   logic [31:0]         rd;
   logic [7:0]          wd;
   logic [1:0]          sel;

   assign setup  = i_apb.psel & ~i_apb.penable;
   assign access = i_apb.psel & i_apb.penable;
   assign hit    = reg_hit(i_apb.paddr);
   assign wr     = access & i_apb.pwrite & hit;
   assign wd     = i_apb.pwdata[7:0];

   always_comb begin
      nxt_state   = state_ff;
      rd          = '0;
      sense_wrap  = 1'b0;
      calib_wrap  = 1'b0;
      clr_slot    = 1'b0;
      set_slot_sw = 1'b0;
      clr_sense   = 1'b0;
      clr_calib   = 1'b0;
      clr_irq     = 1'b0;
      sel         = '0;
      key_pulse   = '0;

      // ---------------------------------------------------------------
      // Timebase
      // ---------------------------------------------------------------
      nxt_state.div     = 3'(state_ff.div + 3'h1);
      nxt_state.start_q = state_ff.start;
      nxt_state.sync    = 1'b0;
      tick4 = state_ff.div[1:0] == DIV4_LAST;
      case (state_ff.cal_sel)
         2'h0:    cal_tick = 1'b1;
         2'h1:    cal_tick = state_ff.div[0];
         2'h2:    cal_tick = tick4;
         default: cal_tick = state_ff.div == DIV_LAST;
      endcase
      rise = state_ff.start & ~state_ff.start_q;

      // ---------------------------------------------------------------
      // Which modules govern the end of the slot
      // ---------------------------------------------------------------
      for (int m = 0; m < CTK_NMOD; m++) begin
         active[m] = |state_ff.ctrl1[m][C1_PAD +: CTK_NKEY];
      end
      // A scan with no pad enabled ends only when every module is done (module 0 alone when shared)
      part = (|active) ? active : '1;
      gov_done = state_ff.shared ? state_ff.done[0]
                                 : &(state_ff.done | ~part);
      slot_end = state_ff.run & gov_done;

      // ---------------------------------------------------------------
      // Per-module slot and sense counters
      // ---------------------------------------------------------------
      for (int m = 0; m < CTK_NMOD; m++) begin
         mod_on[m] = state_ff.run & ~gov_done &
                     ~(state_ff.shared ? state_ff.done[0]
                                       : state_ff.done[m]);
         slot_tick[m] = state_ff.ctrl1[m][C1_TSS] ? tick4
                        : (i_ref_osc[m] &
                           state_ff.ctrl1[m][C1_ROEN]);
         sel = state_ff.ctrl0[m][C0_MUX +: 2];
         key_pulse[m] = i_key_osc[m*CTK_NKEY + int'(sel)] &
                        state_ff.ctrl1[m][C1_PAD + int'(sel)] &
                        state_ff.ctrl1[m][C1_KOEN];

         if (!state_ff.start) begin
            nxt_state.unit[m]  = '0;
            nxt_state.sense[m] = '0;
         end else if (rise) begin
            nxt_state.slot[m] = state_ff.preload;
            nxt_state.done[m] = 1'b0;
         end else if (mod_on[m]) begin
            if (slot_tick[m]) begin
               nxt_state.unit[m] = 5'(state_ff.unit[m] + 5'h01);
               if (state_ff.unit[m] == UNIT_MAX) begin
                  nxt_state.slot[m] = 8'(state_ff.slot[m] + 8'h01);
                  if (state_ff.slot[m] == SLOT_MAX) begin
                     nxt_state.done[m] = 1'b1;
                  end
               end
            end
            if (key_pulse[m]) begin
               nxt_state.sense[m] = 16'(state_ff.sense[m] + 16'h0001);
               if (state_ff.sense[m] == CNT_MAX) begin
                  sense_wrap = 1'b1;
               end
            end
         end
      end

      // ---------------------------------------------------------------
      // Calibration counter
      // ---------------------------------------------------------------
      if (!state_ff.start) begin
         nxt_state.calib = '0;
      end else if (state_ff.run && !gov_done && cal_tick) begin
         nxt_state.calib = 16'(state_ff.calib + 16'h0001);
         calib_wrap = state_ff.calib == CNT_MAX;
      end

      // ---------------------------------------------------------------
      // Run control
      // ---------------------------------------------------------------
      if (!state_ff.start) begin
         nxt_state.run = 1'b0;
      end else if (rise) begin
         nxt_state.run  = 1'b1;
         nxt_state.sync = 1'b1;
      end else if (slot_end) begin
         nxt_state.run = 1'b0;
      end

      // ---------------------------------------------------------------
      // Register writes
      // ---------------------------------------------------------------
      if (wr) begin
         if (i_apb.paddr == ADR_GCTRL) begin
            nxt_state.start   = wd[G_START];
            nxt_state.shared  = wd[G_SHARED];
            nxt_state.cal_sel = wd[G_CALSEL +: 2];
            clr_slot    = ~wd[G_SLOT_OV];
            set_slot_sw = wd[G_SLOT_OV];
            clr_sense   = ~wd[G_SENSE_OV];
            clr_calib   = ~wd[G_CALIB_OV];
         end else if (i_apb.paddr == ADR_PRELOAD) begin
            nxt_state.preload = wd;
         end else if (i_apb.paddr == ADR_IRQ) begin
            clr_irq = ~wd[IRQ_REQ];
         end
         for (int m = 0; m < CTK_NMOD; m++) begin
            if (mod_hit(i_apb.paddr, m, MOD_CTRL0)) begin
               nxt_state.ctrl0[m] = wd;
            end else if (mod_hit(i_apb.paddr, m, MOD_CTRL1)) begin
               nxt_state.ctrl1[m] = wd & C1_WMASK;
            end
         end
      end

      // ---------------------------------------------------------------
      // Sticky flags: a hardware set wins over a same-cycle clear
      // ---------------------------------------------------------------
      nxt_state.slot_ov  = (state_ff.slot_ov & ~clr_slot) | set_slot_sw |
                           slot_end;
      nxt_state.irq      = (state_ff.irq & ~clr_irq) |
                           slot_end;
      nxt_state.sense_ov = (state_ff.sense_ov & ~clr_sense) |
                           sense_wrap;
      nxt_state.calib_ov = (state_ff.calib_ov & ~clr_calib) |
                           calib_wrap;

      // ---------------------------------------------------------------
      // Read data, captured in the setup phase
      // ---------------------------------------------------------------
      if (i_apb.paddr == ADR_GCTRL) begin
         rd[G_SLOT_OV]      = state_ff.slot_ov;
         rd[G_START]        = state_ff.start;
         rd[G_SENSE_OV]     = state_ff.sense_ov;
         rd[G_CALIB_OV]     = state_ff.calib_ov;
         rd[G_SHARED]       = state_ff.shared;
         rd[G_CALSEL +: 2]  = state_ff.cal_sel;
      end else if (i_apb.paddr == ADR_PRELOAD) begin
         rd[7:0] = state_ff.preload;
      end else if (i_apb.paddr == ADR_CALIB) begin
         rd[15:0] = state_ff.calib;
      end else if (i_apb.paddr == ADR_IRQ) begin
         rd[IRQ_REQ] = state_ff.irq;
      end
      for (int m = 0; m < CTK_NMOD; m++) begin
         if (mod_hit(i_apb.paddr, m, MOD_CTRL0)) begin
            rd[7:0] = state_ff.ctrl0[m];
         end else if (mod_hit(i_apb.paddr, m, MOD_CTRL1)) begin
            rd[7:0] = state_ff.ctrl1[m];
         end else if (mod_hit(i_apb.paddr, m, MOD_COUNT)) begin
            rd[15:0] = state_ff.sense[m];
         end
      end
      if (setup) begin
         nxt_state.rdata = rd;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         state_ff       <= '0;
         state_ff.ctrl0 <= {CTK_NMOD{CTRL_RST}};
         state_ff.ctrl1 <= {CTK_NMOD{CTRL_RST}};
      end else if (i_ce) begin
         state_ff <= nxt_state;
      end
   end

   // ----------------------------------------------------------------
   // Bus answers: zero wait states, read word latched at setup
   // ----------------------------------------------------------------
   // A frozen block answers nothing, so no write can be lost
   assign o_pready    = access & i_ce;
   assign o_pslverr   = access & i_ce & ~hit;
   assign o_prdata    = state_ff.rdata;
   assign o_osc_sync  = state_ff.sync;
   assign o_touch_irq = state_ff.irq;

   // ----------------------------------------------------------------
   // Analog front-end controls
   // ----------------------------------------------------------------
   genvar gm;
   genvar gk;
   generate
      for (gm = 0; gm < CTK_NMOD; gm++) begin : g_mod
         // Oscillators only run inside a slot, so a stopped scan draws
         // no oscillator current even with the enables left set
         assign o_ref_osc_run[gm] = state_ff.run &
                                    state_ff.ctrl1[gm][C1_ROEN];
         assign o_freq_double[gm] = state_ff.ctrl0[gm][C0_DBL];
         assign o_filter_en[gm]   = state_ff.ctrl0[gm][C0_FILT];
         assign o_hop_hw[gm]      = state_ff.ctrl0[gm][C0_HOPHW];
         assign o_hop_freq_sel[gm*3 +: 3] =
            state_ff.ctrl0[gm][C0_HOPHW] ? 3'h0
            : state_ff.ctrl0[gm][C0_HOPF +: 3];
         assign o_hop_khz[gm*11 +: 11] =
            HOP_KHZ[state_ff.ctrl0[gm][C0_HOPF +: 3]];
         for (gk = 0; gk < CTK_NKEY; gk++) begin : g_key
            assign o_pad_sense_en[gm*CTK_NKEY + gk] =
               state_ff.ctrl1[gm][C1_PAD + gk];
            assign o_key_osc_run[gm*CTK_NKEY + gk] = state_ff.run &
               state_ff.ctrl1[gm][C1_KOEN] &
               state_ff.ctrl1[gm][C1_PAD + gk];
         end
      end
   endgenerate

endmodule
`default_nettype wire

/* sim/ctk_scan_asserts.sv */
`default_nettype none
module ctk_scan_chk
   import ctk_pkg::*;
(
   input wire logic                         i_clk,
   input wire logic                         i_resetn,
   input wire logic                         i_ce,
   input wire ctk_apb_req_t                 i_apb,
   input wire logic                         o_pslverr,
   input wire logic [CTK_NMOD*CTK_NKEY-1:0] o_key_osc_run,
   input wire logic [CTK_NMOD-1:0]          o_ref_osc_run,
   input wire logic [CTK_NMOD*CTK_NKEY-1:0] o_pad_sense_en,
   input wire logic [CTK_NMOD-1:0]          o_freq_double,
   input wire logic [CTK_NMOD-1:0]          o_filter_en,
   input wire logic [CTK_NMOD-1:0]          o_hop_hw,
   input wire logic [CTK_NMOD*3-1:0]        o_hop_freq_sel,
   input wire logic [CTK_NMOD*11-1:0]       o_hop_khz,
   input wire logic                         o_osc_sync,
   input wire logic                         o_touch_irq
);
   timeunit 1ns;
   timeprecision 1ns;
   logic wr;
   logic idle;
   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   // Clock enable gates every write
   assign wr = i_ce & i_apb.psel & i_apb.penable & i_apb.pwrite;
   assign idle = (o_key_osc_run == '0) && (o_ref_osc_run == '0);
   a_double_follow: assert property (wr && i_apb.paddr == ADR_MOD_BASE
      |=> o_freq_double[0] == $past(i_apb.pwdata[C0_DBL]))
      else $error("frequency double bit not applied");
   a_filter_follow: assert property (wr && i_apb.paddr == ADR_MOD_BASE
      |=> o_filter_en[0] == $past(i_apb.pwdata[C0_FILT]))
      else $error("filter enable not applied");
   a_hop_forced: assert property (
      o_hop_hw[0] |-> o_hop_freq_sel[2:0] == 3'h0)
      else $error("software hop code leaks in hardware mode");
   a_hop_table: assert property (!o_hop_hw[0]
      |-> o_hop_khz[10:0] == HOP_KHZ[o_hop_freq_sel[2:0]])
      else $error("hop frequency does not match code");
   a_pad_map: assert property (wr && i_apb.paddr ==
      ADR_MOD_BASE + MOD_STRIDE + MOD_CTRL1
      |=> o_pad_sense_en[7:4] == $past(i_apb.pwdata[3:0]))
      else $error("module 1 pad bits map to wrong keys");
   a_key_gated: assert property (
      (o_key_osc_run & ~o_pad_sense_en) == '0)
      else $error("key oscillator runs on an I/O pin");
   a_irq_sticky: assert property (o_touch_irq &&
      !(wr && i_apb.paddr == ADR_IRQ) |=> o_touch_irq)
      else $error("interrupt dropped without software clear");
   a_stop_at_irq: assert property ($rose(o_touch_irq) |-> idle)
      else $error("oscillators still run at slot end");
   a_sync_once: assert property (o_osc_sync && i_ce |=> !o_osc_sync)
      else $error("sync pulse longer than one cycle");
   a_sw_no_irq: assert property (
      wr && i_apb.paddr == ADR_GCTRL && idle &&
      !o_touch_irq && !o_osc_sync |=> !o_touch_irq)
      else $error("software flag write raised the interrupt");
   c_irq: cover property ($rose(o_touch_irq));
   c_sync: cover property (o_osc_sync);
   c_err: cover property (i_apb.psel && i_apb.penable && o_pslverr);
endmodule
bind ctk_scan ctk_scan_chk u_ctk_scan_chk (
   .i_clk(i_clk), .i_resetn(i_resetn), .i_ce(i_ce), .i_apb(i_apb),
   .o_pslverr(o_pslverr), .o_key_osc_run(o_key_osc_run),
   .o_ref_osc_run(o_ref_osc_run), .o_pad_sense_en(o_pad_sense_en),
   .o_freq_double(o_freq_double), .o_filter_en(o_filter_en),
   .o_hop_hw(o_hop_hw), .o_hop_freq_sel(o_hop_freq_sel),
   .o_hop_khz(o_hop_khz), .o_osc_sync(o_osc_sync),
   .o_touch_irq(o_touch_irq)
);
`default_nettype wire

/* sim/ctk_pads.sv */
`default_nettype none
module ctk_pads
   import ctk_pkg::*;
(
   input  wire logic                         i_clk,
   input  wire logic                         i_resetn,
   input  wire logic [CTK_NMOD*CTK_NKEY-1:0] i_key_run,
   input  wire logic [CTK_NMOD-1:0]          i_ref_run,
   input  wire logic [CTK_NMOD-1:0]          i_double,
   output logic      [CTK_NMOD*CTK_NKEY-1:0] o_key_osc,
   output logic      [CTK_NMOD-1:0]          o_ref_osc
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] ph_ff;
   // ----------------------------------------------------------------
   // Pad oscillators
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         ph_ff     <= 3'h0;
         o_key_osc <= '0;
         o_ref_osc <= '0;
      end else begin
         ph_ff <= ph_ff + 3'h1;
         // Phase offset by pad index, so adjacent keys never pulse in lockstep
         for (int i = 0; i < CTK_NMOD*CTK_NKEY; i++) begin
            o_key_osc[i] <= i_key_run[i] &&
               ((ph_ff + 3'(i)) & (i_double[i/4] ? 3'h1 : 3'h3)) == 3'h0;
         end
         // Slow reference, one edge in eight clocks
         for (int m = 0; m < CTK_NMOD; m++) begin
            o_ref_osc[m] <= i_ref_run[m] && (ph_ff == 3'(m));
         end
      end
   end
endmodule
`default_nettype wire

/* sim/tb_top.sv */
`default_nettype none
module tb_top
   import ctk_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [31:0] d; logic e;} ctk_exp_t;
   logic         i_clk;
   logic         i_resetn;
   ctk_apb_req_t apb;
   logic         pready, pslverr, sync, irq;
   logic [31:0]  prdata;
   logic [19:0]  key_osc, key_run, pad_en;
   logic [4:0]   ref_osc, ref_run, dbl, filt, hw;
   logic [14:0]  hop_sel;
   ctk_exp_t     q[$];
   int           fails, n_compared, cyc, npulse, base, n, lo;
   logic [7:0]   rnd, v0, v1;
   logic [11:0]  b;
   logic         pend;
   ctk_scan u_ctk_scan (.i_clk(i_clk), .i_resetn(i_resetn), .i_ce(1'b1),
      .i_apb(apb), .o_pready(pready), .o_pslverr(pslverr), .o_prdata(prdata),
      .i_key_osc(key_osc), .i_ref_osc(ref_osc), .o_key_osc_run(key_run),
      .o_ref_osc_run(ref_run), .o_pad_sense_en(pad_en), .o_freq_double(dbl),
      .o_filter_en(filt), .o_hop_hw(hw), .o_hop_freq_sel(hop_sel),
      .o_hop_khz(), .o_osc_sync(sync), .o_touch_irq(irq));
   ctk_pads u_ctk_pads (.i_clk(i_clk), .i_resetn(i_resetn),
      .i_key_run(key_run), .i_ref_run(ref_run), .i_double(dbl),
      .o_key_osc(key_osc), .o_ref_osc(ref_osc));
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %0t got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("compared %0d failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Request held until pready is sampled high at a rising edge
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
      @(posedge i_clk);
      apb <= '{a, 1'b1, 1'b0, w, d};
      @(posedge i_clk);
      apb.penable <= 1'b1;
      do @(posedge i_clk); while (pready !== 1'b1);
      apb.psel <= 1'b0;
      apb.penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] d,
                     input logic e = 1'b0);
      q.push_back('{d, e});
      xfer(1'b0, a, 32'h0);
   endtask
   // ----------------------------------------------------------------
   // Clock, monitor and timeout
   // ----------------------------------------------------------------
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         test_done();
      end
      if (pend && key_run[0]) npulse++;
      // A pulse in the overflow cycle falls outside the slot
      pend = i_resetn && key_osc[0] && key_run[0];
      if (apb.psel && apb.penable && pready && !apb.pwrite) begin
         chk(prdata, q[0].d);
         chk(32'(pslverr), 32'(q[0].e));
         void'(q.pop_front());
      end
   end
   // ----------------------------------------------------------------
   // Stimulus
   // ----------------------------------------------------------------
   initial begin
      i_resetn = 1'b0;
      apb = '0;
      rnd = 8'h08;
      repeat (4) @(posedge i_clk);
      i_resetn <= 1'b1;
      rd(ADR_GCTRL, 32'h0);
      rd(ADR_MOD_BASE + MOD_CTRL1, 32'h0);
      rd(12'h010, 32'h0, 1'b1);
      for (int m = 0; m < CTK_NMOD; m++) begin
         b = ADR_MOD_BASE + MOD_STRIDE * 12'(m);
         rnd = lfsr_next(rnd);
         v0 = rnd;
         rnd = lfsr_next(rnd);
         v1 = rnd;
         wr(b, 32'(v0));
         wr(b + MOD_CTRL1, 32'(v1));
         rd(b, 32'(v0));
         rd(b + MOD_CTRL1, 32'(v1 & C1_WMASK));
         @(posedge i_clk);
         chk({dbl[m], filt[m], hw[m], hop_sel[3*m +: 3], pad_en[4*m +: 4]},
             {v0[5:3], v0[3] ? 3'h0 : v0[2:0], v1[3:0]});
         wr(b + MOD_CTRL1, 32'h0);
      end
      // Module 0 ticks at fsys/4, module 1 on its slow reference
      wr(ADR_MOD_BASE, 32'h20);
      wr(ADR_MOD_BASE + MOD_CTRL1, 32'hB1);
      wr(ADR_MOD_BASE + MOD_STRIDE + MOD_CTRL1, 32'h31);
      wr(ADR_PRELOAD, 32'hFE);
      for (int s = 1; s >= 0; s--) begin
         wr(ADR_GCTRL, 32'(s) << G_SHARED);
         base = npulse;
         wr(ADR_GCTRL, (32'(s) << G_SHARED) | 32'h20);
         n = 0;
         do begin
            @(posedge i_clk);
            n++;
         end while (irq !== 1'b1 && n < 2000);
         // 64 slot ticks span 63 tick periods from the first tick
         lo = (((256 - 32'hFE) * 32) - 1) * (s ? 4 : 8);
         chk(32'(n >= lo && n <= lo + 30), 32'h1);
         rd(ADR_GCTRL, (32'(s) << G_SHARED) | 32'h60);
         rd(ADR_IRQ, 32'h1);
         if (s == 1) rd(ADR_MOD_BASE + MOD_COUNT, 32'(npulse - base));
         wr(ADR_IRQ, 32'h0);
         wr(ADR_GCTRL, 32'h0);
         rd(ADR_GCTRL, 32'h0);
         rd(ADR_MOD_BASE + MOD_COUNT, 32'h0);
         chk(32'(irq), 32'h0);
      end
      // Software may set the slot flag but not the sense/calib flags
      wr(ADR_GCTRL, 32'h58);
      rd(ADR_GCTRL, 32'h40);
      chk(32'(irq), 32'h0);
      wr(ADR_GCTRL, 32'h0);
      rd(ADR_GCTRL, 32'h0);
      test_done();
   end
endmodule
`default_nettype wire
